// ==== core/dpc_pkg.sv ====
package dpc_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CLK_RX   = 8'h08;
    localparam logic [7:0] ADDR_PLL_EN   = 8'h0a;
    localparam logic [7:0] ADDR_PLL_LOOP = 8'h0c;
    localparam logic [7:0] ADDR_PLL_DIV  = 8'h0d;

    // ----------------------------------------
    // Reset values and writable bits
    // ----------------------------------------
    localparam logic [7:0] RST_CLK_RX    = 8'h30;
    localparam logic [7:0] RST_PLL_EN    = 8'h40;
    localparam logic [7:0] RST_PLL_LOOP  = 8'hd1;
    localparam logic [7:0] RST_PLL_DIV   = 8'hd8;
    localparam logic [7:0] MASK_CLK_RX   = 8'hf0;
    localparam logic [7:0] MASK_PLL_EN   = 8'hff;
    localparam logic [7:0] MASK_PLL_LOOP = 8'hdf;
    localparam logic [7:0] MASK_PLL_DIV  = 8'hdc;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CONV_DCC_BIT   = 7;
    localparam int REF_DCC_BIT    = 6;
    localparam int CONV_CROSS_BIT = 5;
    localparam int REF_CROSS_BIT  = 4;
    localparam int PLL_EN_BIT     = 7;
    localparam int MAN_EN_BIT     = 6;
    localparam int BAND_LSB       = 0;
    localparam int BAND_W         = 6;
    localparam int LOOP_BW_LSB    = 6;
    localparam int CP_LSB         = 0;
    localparam int CP_W           = 5;
    localparam int CTRL_DIV_LSB   = 6;
    localparam int XCTRL_BIT      = 4;
    localparam int OSC_DIV_LSB    = 2;

    // ----------------------------------------
    // Decoded configuration
    // ----------------------------------------
    typedef struct packed {
        logic                convDutyCorrEn;
        logic                refDutyCorrEn;
        logic                convCrossCorrEn;
        logic                refCrossCorrEn;
        logic                pllEnable;
        logic                manualBandEn;
        logic [BAND_W-1:0]   manualBandSelect;
        logic [1:0]          loopBandwidth;
        logic [CP_W-1:0]     chargePumpCurrent;
        logic [1:0]          controllerClockDivider;
        logic [4:0]          controllerClockRatio;
        logic                crossControlEn;
        logic [1:0]          oscillatorDivider;
        logic [2:0]          oscillatorRatio;
    } dpc_cfg_s;
endpackage

// ==== core/dpc_clock_config.sv ====
`timescale 1ns/1ns
module dpc_clock_config
(
    // Clock, reset, enable
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              clkEn,
    // Serial port register access
    input  wire logic [7:0]        regAddr,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regWrEn,
    input  wire logic              regRdEn,
    output logic      [7:0]        regRdData,
    // Configuration to clock receivers and PLL
    output dpc_pkg::dpc_cfg_s      cfg
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rstMeta_ff;
    logic rstSync_ff;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end
        else
        begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire hitClkRx  = (regAddr == dpc_pkg::ADDR_CLK_RX);
    wire hitPllEn  = (regAddr == dpc_pkg::ADDR_PLL_EN);
    wire hitLoop   = (regAddr == dpc_pkg::ADDR_PLL_LOOP);
    wire hitDiv    = (regAddr == dpc_pkg::ADDR_PLL_DIV);
    wire wrClkRx   = clkEn && regWrEn && hitClkRx;
    wire wrPllEn   = clkEn && regWrEn && hitPllEn;
    wire wrLoop    = clkEn && regWrEn && hitLoop;
    wire wrDiv     = clkEn && regWrEn && hitDiv;

    logic [7:0] clkRx_ff;
    logic [7:0] pllEn_ff;
    logic [7:0] pllLoop_ff;
    logic [7:0] pllDiv_ff;
    logic [7:0] regRdData_ff;

    // Reserved bits are masked on write so they always read zero
    wire [7:0] nxt_clkRx   = wrClkRx ? (regWrData & dpc_pkg::MASK_CLK_RX)   : clkRx_ff;
    wire [7:0] nxt_pllEn   = wrPllEn ? (regWrData & dpc_pkg::MASK_PLL_EN)   : pllEn_ff;
    wire [7:0] nxt_pllLoop = wrLoop  ? (regWrData & dpc_pkg::MASK_PLL_LOOP) : pllLoop_ff;
    wire [7:0] nxt_pllDiv  = wrDiv   ? (regWrData & dpc_pkg::MASK_PLL_DIV)  : pllDiv_ff;

    // Unmapped addresses read zero
    wire [7:0] rdMux = hitClkRx ? clkRx_ff   :
                       hitPllEn ? pllEn_ff   :
                       hitLoop  ? pllLoop_ff :
                       hitDiv   ? pllDiv_ff  : 8'h00;
    wire [7:0] nxt_regRdData = (clkEn && regRdEn) ? rdMux : regRdData_ff;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rstSync_ff)
    begin
        if (!rstSync_ff)
        begin
            clkRx_ff     <= dpc_pkg::RST_CLK_RX;
            pllEn_ff     <= dpc_pkg::RST_PLL_EN;
            pllLoop_ff   <= dpc_pkg::RST_PLL_LOOP;
            pllDiv_ff    <= dpc_pkg::RST_PLL_DIV;
            regRdData_ff <= 8'h00;
        end
        else
        begin
            clkRx_ff     <= nxt_clkRx;
            pllEn_ff     <= nxt_pllEn;
            pllLoop_ff   <= nxt_pllLoop;
            pllDiv_ff    <= nxt_pllDiv;
            regRdData_ff <= nxt_regRdData;
        end
    end

    assign regRdData = regRdData_ff;

    // ----------------------------------------
    // Field outputs
    // ----------------------------------------
    wire [1:0] ctrlDivCode = pllDiv_ff[dpc_pkg::CTRL_DIV_LSB +: 2];
    wire [1:0] oscDivCode  = pllDiv_ff[dpc_pkg::OSC_DIV_LSB +: 2];

    // Ratio is 2 shifted by the code: 2, 4, 8, 16
    wire [4:0] ctrlRatio = 5'h02 << ctrlDivCode;
    // Upper codes saturate at four
    wire [2:0] oscRatio  = oscDivCode[1] ? 3'h4 : (oscDivCode[0] ? 3'h2 : 3'h1);

    assign cfg.convDutyCorrEn         = clkRx_ff[dpc_pkg::CONV_DCC_BIT];
    assign cfg.refDutyCorrEn          = clkRx_ff[dpc_pkg::REF_DCC_BIT];
    assign cfg.convCrossCorrEn        = clkRx_ff[dpc_pkg::CONV_CROSS_BIT];
    assign cfg.refCrossCorrEn         = clkRx_ff[dpc_pkg::REF_CROSS_BIT];
    assign cfg.pllEnable              = pllEn_ff[dpc_pkg::PLL_EN_BIT];
    assign cfg.manualBandEn           = pllEn_ff[dpc_pkg::MAN_EN_BIT];
    assign cfg.manualBandSelect       = pllEn_ff[dpc_pkg::BAND_LSB +: dpc_pkg::BAND_W];
    assign cfg.loopBandwidth          = pllLoop_ff[dpc_pkg::LOOP_BW_LSB +: 2];
    assign cfg.chargePumpCurrent      = pllLoop_ff[dpc_pkg::CP_LSB +: dpc_pkg::CP_W];
    assign cfg.controllerClockDivider = ctrlDivCode;
    assign cfg.controllerClockRatio   = ctrlRatio;
    assign cfg.crossControlEn         = pllDiv_ff[dpc_pkg::XCTRL_BIT];
    assign cfg.oscillatorDivider      = oscDivCode;
    assign cfg.oscillatorRatio        = oscRatio;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cbA @(posedge sys_clk);
    endclocking
    default disable iff (!rstSync_ff);

    sequence s_wrClkRx;
        clkEn && regWrEn && regAddr == dpc_pkg::ADDR_CLK_RX;
    endsequence

    sequence s_wrPllEn;
        clkEn && regWrEn && regAddr == dpc_pkg::ADDR_PLL_EN;
    endsequence

    property p_refDcc;
        s_wrClkRx |=> cfg.refDutyCorrEn == $past(regWrData[6]);
    endproperty
    a_refDcc: assert property (p_refDcc) else $error("Reference duty correction bit wrong");

    property p_crossBits;
        s_wrClkRx |=> cfg.convCrossCorrEn == $past(regWrData[5]) && cfg.refCrossCorrEn == $past(regWrData[4]);
    endproperty
    a_crossBits: assert property (p_crossBits) else $error("Crossing correction bits wrong");

    property p_convDcc;
        s_wrClkRx |=> cfg.convDutyCorrEn == $past(regWrData[7]);
    endproperty
    a_convDcc: assert property (p_convDcc) else $error("Converter duty correction bit wrong");

    property p_pllEnBand;
        s_wrPllEn |=> cfg.pllEnable == $past(regWrData[7]) && cfg.manualBandEn == $past(regWrData[6])
                      && cfg.manualBandSelect == $past(regWrData[5:0]);
    endproperty
    a_pllEnBand: assert property (p_pllEnBand) else $error("PLL enable or band wrong");

    property p_loop;
        clkEn && regWrEn && regAddr == dpc_pkg::ADDR_PLL_LOOP
            |=> cfg.loopBandwidth == $past(regWrData[7:6]) && cfg.chargePumpCurrent == $past(regWrData[4:0]);
    endproperty
    a_loop: assert property (p_loop) else $error("Loop filter fields wrong");

    property p_ctrlRatio;
        (cfg.controllerClockDivider == 2'h0 && cfg.controllerClockRatio == 5'h02) ||
        (cfg.controllerClockDivider == 2'h1 && cfg.controllerClockRatio == 5'h04) ||
        (cfg.controllerClockDivider == 2'h2 && cfg.controllerClockRatio == 5'h08) ||
        (cfg.controllerClockDivider == 2'h3 && cfg.controllerClockRatio == 5'h10);
    endproperty
    a_ctrlRatio: assert property (p_ctrlRatio) else $error("Controller clock ratio wrong");

    property p_oscRatio;
        (cfg.oscillatorDivider == 2'h0 && cfg.oscillatorRatio == 3'h1) ||
        (cfg.oscillatorDivider == 2'h1 && cfg.oscillatorRatio == 3'h2) ||
        (cfg.oscillatorDivider[1] && cfg.oscillatorRatio == 3'h4);
    endproperty
    a_oscRatio: assert property (p_oscRatio) else $error("Oscillator ratio wrong");

    property p_xctrl;
        clkEn && regWrEn && regAddr == dpc_pkg::ADDR_PLL_DIV |=> cfg.crossControlEn == $past(regWrData[4]);
    endproperty
    a_xctrl: assert property (p_xctrl) else $error("Cross-point controller bit wrong");

    property p_hold;
        !(clkEn && regWrEn) |=> $stable(cfg);
    endproperty
    a_hold: assert property (p_hold) else $error("Configuration changed without a write");

    sequence s_wrThenRd;
        s_wrPllEn ##1 (clkEn && regRdEn && !regWrEn && regAddr == dpc_pkg::ADDR_PLL_EN);
    endsequence

    property p_readBack;
        s_wrThenRd |=> regRdData == $past(regWrData, 2);
    endproperty
    a_readBack: assert property (p_readBack) else $error("Read back differs from last write");

    property p_frozen;
        !clkEn |=> $stable(cfg) && $stable(regRdData);
    endproperty
    a_frozen: assert property (p_frozen) else $error("State changed while clock enable was low");

    property p_unmappedRead;
        clkEn && regRdEn && !(hitClkRx || hitPllEn || hitLoop || hitDiv) |=> regRdData == 8'h00;
    endproperty
    a_unmappedRead: assert property (p_unmappedRead) else $error("Unmapped read returned nonzero data");

    property p_reservedZero;
        (clkRx_ff & ~dpc_pkg::MASK_CLK_RX) == 8'h00 && (pllLoop_ff & ~dpc_pkg::MASK_PLL_LOOP) == 8'h00
            && (pllDiv_ff & ~dpc_pkg::MASK_PLL_DIV) == 8'h00;
    endproperty
    a_reservedZero: assert property (p_reservedZero) else $error("Reserved register bit is set");

endmodule

// ==== dv/dpc_clock_config_tb.sv ====
`timescale 1ns/1ns
module dpc_clock_config_tb;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdExp;
    } dpc_row_s;

    logic              sys_clk   = 1'b0;
    logic              rst_n     = 1'b0;
    logic              clkEn     = 1'b1;
    logic [7:0]        regAddr   = 8'h00;
    logic [7:0]        regWrData = 8'h00;
    logic              regWrEn   = 1'b0;
    logic              regRdEn   = 1'b0;
    logic [7:0]        regRdData;
    dpc_pkg::dpc_cfg_s cfg;
    int                n_fail    = 0;
    int                n_tests   = 0;
    dpc_row_s          rows [9];

    always #25 sys_clk = ~sys_clk;

    dpc_clock_config dut_u
    (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regWrEn   (regWrEn),
        .regRdEn   (regRdEn),
        .regRdData (regRdData),
        .cfg       (cfg)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Entered 5 ns after an edge, leaves 5 ns after the next
    // Strobes stay up on return so no strobe is driven twice in one time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        regRdEn   = 1'b0;
        @(posedge sys_clk);
        #5;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        regAddr = a;
        regWrEn = 1'b0;
        regRdEn = 1'b1;
        @(posedge sys_clk);
        #5;
        chk(name, exp, regRdData);
    endtask

    task automatic print_verdict;
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog at 2000 cycles, whole run is about 60 cycles
    // ----------------------------------------
    initial
    begin
        #(2000 * 50);
        n_fail++;
        print_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        int         i;
        logic [1:0] c;
        rows = '{'{8'h08, 8'hff, 8'hf0}, '{8'h08, 8'h0f, 8'h00}, '{8'h0a, 8'hbf, 8'hbf},
                 '{8'h0a, 8'h40, 8'h40}, '{8'h0c, 8'hff, 8'hdf}, '{8'h0c, 8'h20, 8'h00},
                 '{8'h0d, 8'hff, 8'hdc}, '{8'h0d, 8'h23, 8'h00}, '{8'h20, 8'hff, 8'h00}};
        repeat (20) @(posedge sys_clk);
        #5;
        rst_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        #5;
        rd(8'h08, 8'h30, "rxDefault");
        rd(8'h0a, 8'h40, "pllEnDefault");
        rd(8'h0c, 8'hd1, "loopDefault");
        rd(8'h0d, 8'hd8, "divDefault");
        // Default divide of 16 is the slowest controller clock, safe before software picks one
        chk("ctrlRatioDefault", 8'h10, {3'h0, cfg.controllerClockRatio});
        for (i = 0; i < 9; i++)
        begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rdExp, "rowReadback");
        end
        wr(8'h0a, 8'h85);
        chk("bandCfg", 8'h85, {cfg.pllEnable, cfg.manualBandEn, cfg.manualBandSelect});
        wr(8'h08, 8'h90);
        chk("rxCfg", 8'h09, {4'h0, cfg.convDutyCorrEn, cfg.refDutyCorrEn,
            cfg.convCrossCorrEn, cfg.refCrossCorrEn});
        wr(8'h0c, 8'h5e);
        chk("loopCfg", 8'h5e, {cfg.loopBandwidth, 1'b0, cfg.chargePumpCurrent});
        for (i = 0; i < 4; i++)
        begin
            c = i[1:0];
            // Reserved bit 5 written high to show it is dropped
            wr(8'h0d, {c, 1'b1, c[0], c, 2'b00});
            chk("ctrlRatio", (c == 2'd0) ? 8'h02 : (c == 2'd1) ? 8'h04 : (c == 2'd2) ? 8'h08 : 8'h10,
                {3'h0, cfg.controllerClockRatio});
            chk("ctrlDiv", {6'h0, c}, {6'h0, cfg.controllerClockDivider});
            chk("oscRatio", (c == 2'd0) ? 8'h01 : (c == 2'd1) ? 8'h02 : 8'h04,
                {5'h0, cfg.oscillatorRatio});
            chk("oscDiv", {6'h0, c}, {6'h0, cfg.oscillatorDivider});
            chk("crossCtrl", {7'h0, c[0]}, {7'h0, cfg.crossControlEn});
        end
        // Frozen clock enable must drop the write
        clkEn = 1'b0;
        wr(8'h0a, 8'h00);
        clkEn = 1'b1;
        rd(8'h0a, 8'h85, "clkEnFrozen");
        // Write and read on one edge: read sees the old value
        regAddr   = 8'h0c;
        regWrData = 8'hc0;
        regWrEn   = 1'b1;
        regRdEn   = 1'b1;
        @(posedge sys_clk);
        #5;
        chk("sameEdgeRead", 8'h5e, regRdData);
        rd(8'h0c, 8'hc0, "afterSameEdge");
        // Reset in mid-run restores defaults
        rst_n   = 1'b0;
        regRdEn = 1'b0;
        @(posedge sys_clk);
        #5;
        rst_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        #5;
        rd(8'h0a, 8'h40, "pllEnAfterReset");
        rd(8'h0d, 8'hd8, "divAfterReset");
        print_verdict();
    end
endmodule
